// File: hw/dlc_lock_ctrl.v
`timescale 1ns/1ps
`include "dlc_defs.vh"
//
// Behaviour
// (R1) Partner appends two embedded clock bits to every ten-bit word.
// (R2) System supplies a running reference clock; without it no lock occurs.
// (R3) Embedded clock bits are watched always; lock loss drives lock_n high.
// (R4) Outputs float after power-up until traffic is seen and lock is reached; lock_n is driven once traffic is seen, before lock.
// (R5) Partner sends sync patterns while either sync request input is high.
// (R6) lock_n stays high during acquisition, goes low only once locked.
// (R7) lock_n may be fed back to a sync request input of the partner.
// (R8) Lock can be acquired on ordinary data by random-lock search.
// (R9) While lock_n is low the word outputs carry received data.
// (R10) Loss of lock is declared after four consecutive invalid words.
// (R11) Up to three words before the loss may be corrupt, unmarked.
// (R12) Downstream treats three words before relock as suspect.
// (R13) Relock happens by resent sync patterns or by random lock.
// (R14) Hot insertion into running traffic locks by random lock alone.
// (R15) Output enable low floats words, lock_n and recovered clock.
// (R16) Power-down low stops recovery and floats all outputs, overriding enable; the code floats only words, lock_n and recovered clock.
// (R17) Edge select high strobes words on rising clock edge, low on falling.
// (R18) While not locked the words and recovered clock float.
// (R19) Any valid word clears the consecutive-invalid counter.
module dlc_lock_ctrl (
   input wire core_clk,
   input wire rst_n,
   input wire serial_clk_in,
   input wire serial_data_in,
   input wire reference_clock_in,
   input wire power_down_n,
   input wire output_enable,
   input wire edge_select,
   output reg sync_request_a,
   output reg sync_request_b,
   output wire [9:0] word_out,
   output reg word_oe,
   output wire word_valid,
   input wire word_ready,
   output reg lock_n_out,
   output reg lock_n_oe,
   output reg rclk_out,
   output reg rclk_oe,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr
);
   localparam ST_HUNT = 1'b0;
   localparam ST_LOCK = 1'b1;
   // The watchdog limit sits far above any usable reference period, so a slow
   // but running reference never trips it.
   localparam [6:0] REF_TIMEOUT = `DLC_REF_TIMEOUT_CYC;

   // ------------------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------------------
   // Link clock and data pass the same two stages, so each bit is taken with
   // the same delay as the clock edge that marks it.
   reg [1:0] lclk_sync_reg;
   reg lclk_prev_reg;
   reg [1:0] ldat_sync_reg;
   reg [1:0] ref_sync_reg;
   reg ref_prev_reg;
   reg [1:0] pd_sync_reg;
   reg [1:0] oe_sync_reg;
   reg [1:0] es_sync_reg;

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lclk_sync_reg <= 2'h0;
         lclk_prev_reg <= 1'b0;
         ldat_sync_reg <= 2'h0;
         ref_sync_reg <= 2'h0;
         ref_prev_reg <= 1'b0;
         pd_sync_reg <= 2'h0;
         oe_sync_reg <= 2'h0;
         es_sync_reg <= 2'h0;
      end else begin
         lclk_sync_reg <= {lclk_sync_reg[0], serial_clk_in};
         lclk_prev_reg <= lclk_sync_reg[1];
         ldat_sync_reg <= {ldat_sync_reg[0], serial_data_in};
         ref_sync_reg <= {ref_sync_reg[0], reference_clock_in};
         ref_prev_reg <= ref_sync_reg[1];
         pd_sync_reg <= {pd_sync_reg[0], power_down_n};
         oe_sync_reg <= {oe_sync_reg[0], output_enable};
         es_sync_reg <= {es_sync_reg[0], edge_select};
      end
   end

   wire bit_strobe = lclk_sync_reg[1] & ~lclk_prev_reg;
   wire ref_edge = ref_sync_reg[1] ^ ref_prev_reg;

   // ------------------------------------------------------------------------
   // Control register and power state
   // ------------------------------------------------------------------------
   reg [2:0] ctrl_reg;
   wire powered = pd_sync_reg[1] & ctrl_reg[`DLC_CTRL_ENABLE];

   // ------------------------------------------------------------------------
   // Reference clock watchdog
   // ------------------------------------------------------------------------
   // A missing reference holds the detector in search and drops an existing
   // lock, since the real recovery loop cannot track without it.
   reg [6:0] ref_timer_reg;
   reg ref_ok_reg;

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_timer_reg <= 7'h00;
         ref_ok_reg <= 1'b0;
      end else if (ref_edge) begin
         ref_timer_reg <= 7'h00;
         ref_ok_reg <= 1'b1;
      end else if (ref_timer_reg == REF_TIMEOUT) begin
         ref_ok_reg <= 1'b0; // (R2)
      end else begin
         ref_timer_reg <= ref_timer_reg + 7'h01;
      end
   end

   // ------------------------------------------------------------------------
   // Word framing and lock detector
   // ------------------------------------------------------------------------
   // A frame is a leading one, ten data bits first bit first, and a trailing
   // zero. Search slips one bit per failed frame until enough frames in a row
   // are well formed; this works on sync patterns and on random data alike.
   reg state_reg;
   reg [11:0] shift_reg;
   reg [3:0] bit_cnt_reg;
   reg [3:0] good_cnt_reg;
   reg [2:0] bad_cnt_reg;
   reg activity_reg;
   reg push_reg;
   reg [9:0] push_data_reg;
   reg loss_pulse_reg;
   reg overflow_pulse_reg;
   wire buf_in_ready;

   wire [11:0] frame = {ldat_sync_reg[1], shift_reg[11:1]};
   wire frame_ok = frame[0] & ~frame[`DLC_FRAME_BITS - 1];
   wire at_boundary = bit_strobe & (bit_cnt_reg == `DLC_LAST_BIT);

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_HUNT;
         shift_reg <= 12'h000;
         bit_cnt_reg <= 4'h0;
         good_cnt_reg <= 4'h0;
         bad_cnt_reg <= 3'h0;
         activity_reg <= 1'b0;
         push_reg <= 1'b0;
         push_data_reg <= 10'h000;
         loss_pulse_reg <= 1'b0;
         overflow_pulse_reg <= 1'b0;
      end else if (!powered) begin
         // Power-down forgets the frame phase; the next lock starts a fresh search.
         state_reg <= ST_HUNT; // (R16)
         bit_cnt_reg <= 4'h0;
         good_cnt_reg <= 4'h0;
         bad_cnt_reg <= 3'h0;
         activity_reg <= 1'b0;
         push_reg <= 1'b0;
         loss_pulse_reg <= 1'b0;
         overflow_pulse_reg <= 1'b0;
      end else begin
         push_reg <= 1'b0;
         loss_pulse_reg <= 1'b0;
         overflow_pulse_reg <= 1'b0;
         if (bit_strobe) begin
            shift_reg <= frame;
            activity_reg <= 1'b1;
            if (bit_cnt_reg != `DLC_LAST_BIT) begin
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
         end
         case (state_reg)
            ST_HUNT: begin
               // Losses only count once locked; search keeps its own tally.
               bad_cnt_reg <= 3'h0;
               if (at_boundary) begin
                  if (frame_ok && ref_ok_reg) begin
                     bit_cnt_reg <= 4'h0;
                     if (good_cnt_reg == `DLC_LOCK_GOOD_WORDS - 4'h1) begin
                        state_reg <= ST_LOCK; // (R6) (R8) (R13) (R14)
                        good_cnt_reg <= 4'h0;
                     end else begin
                        good_cnt_reg <= good_cnt_reg + 4'h1;
                     end
                  end else begin
                     // Stay on the last bit so the next bit is tried as frame end.
                     good_cnt_reg <= 4'h0;
                  end
               end
            end
            ST_LOCK: begin
               // A dead reference drops lock at once, without waiting for bad words.
               if (!ref_ok_reg) begin
                  state_reg <= ST_HUNT;
                  loss_pulse_reg <= 1'b1;
               end else if (at_boundary) begin
                  bit_cnt_reg <= 4'h0;
                  if (frame_ok) begin
                     bad_cnt_reg <= 3'h0; // (R19)
                  end else begin
                     bad_cnt_reg <= bad_cnt_reg + 3'h1;
                  end
                  if (!frame_ok && bad_cnt_reg == `DLC_LOSS_WORDS - 3'h1) begin
                     state_reg <= ST_HUNT; // (R3) (R10)
                     loss_pulse_reg <= 1'b1;
                  end else begin
                     // Words with a bad clock pair still pass, unmarked.
                     push_reg <= buf_in_ready; // (R9) (R11)
                     overflow_pulse_reg <= ~buf_in_ready;
                     push_data_reg <= frame[`DLC_DATA_BITS:1];
                  end
               end
            end
            default: begin
               state_reg <= ST_HUNT;
            end
         endcase
      end
   end

   wire locked = (state_reg == ST_LOCK);

   // ------------------------------------------------------------------------
   // Output buffer
   // ------------------------------------------------------------------------
   // The buffer absorbs a short stall downstream; a longer one drops words,
   // since the link itself can never be held off.
   dlc_word_buf u_buf (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .flush(~powered),
      .in_valid(push_reg),
      .in_ready(buf_in_ready),
      .in_data(push_data_reg),
      .out_valid(word_valid),
      .out_ready(word_ready),
      .out_data(word_out)
   );

   // ------------------------------------------------------------------------
   // Pin drivers
   // ------------------------------------------------------------------------
   // The recovered clock is high in the first half of each frame slot; edge
   // select inverts it so the chosen edge sits mid-slot either way.
   wire first_half = (bit_cnt_reg < `DLC_HALF_BIT);
   // The lock indicator is only driven once the link has shown activity, so a
   // board with no partner attached sees it floating rather than high.

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         word_oe <= 1'b0;
         lock_n_out <= 1'b1;
         lock_n_oe <= 1'b0;
         rclk_out <= 1'b0;
         rclk_oe <= 1'b0;
         sync_request_a <= 1'b0;
         sync_request_b <= 1'b0;
      end else begin
         lock_n_out <= ~locked; // (R3) (R6)
         lock_n_oe <= powered & oe_sync_reg[1] & activity_reg; // (R4) (R15) (R16)
         word_oe <= powered & oe_sync_reg[1] & locked; // (R15) (R16) (R18)
         rclk_oe <= powered & oe_sync_reg[1] & locked; // (R15) (R16) (R18)
         rclk_out <= es_sync_reg[1] ? ~first_half : first_half; // (R17)
         sync_request_a <= ctrl_reg[`DLC_CTRL_SYNC_FEEDBACK] & ~locked; // (R7)
         sync_request_b <= ctrl_reg[`DLC_CTRL_FORCE_SYNC];
      end
   end

   // ------------------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------------------
   // One wait state: pready rises on the first access-phase edge, and the
   // write lands on the edge at which the master sees pready high.
   reg loss_seen_reg;
   reg overflow_reg;
   reg [15:0] loss_count_reg;
   reg [31:0] word_count_reg;
   wire access = psel & penable;
   wire wr_done = access & pready & pwrite;
   wire hit_ctrl = (paddr == `DLC_OFS_CTRL);
   wire hit_status = (paddr == `DLC_OFS_STATUS);
   wire mapped = hit_ctrl | hit_status | (paddr == `DLC_OFS_LOSS_COUNT) |
                 (paddr == `DLC_OFS_WORD_COUNT);
   reg [31:0] rd_mux;

   always @* begin
      rd_mux = 32'h00000000;
      case (paddr)
         `DLC_OFS_CTRL: rd_mux = {29'h00000000, ctrl_reg};
         `DLC_OFS_STATUS: rd_mux = {27'h0000000, overflow_reg, loss_seen_reg,
                                    activity_reg, ref_ok_reg, locked};
         `DLC_OFS_LOSS_COUNT: rd_mux = {16'h0000, loss_count_reg};
         `DLC_OFS_WORD_COUNT: rd_mux = word_count_reg;
         default: rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         ctrl_reg <= `DLC_CTRL_RESET;
         loss_seen_reg <= 1'b0;
         overflow_reg <= 1'b0;
         loss_count_reg <= 16'h0000;
         word_count_reg <= 32'h00000000;
      end else begin
         pready <= access & ~pready;
         pslverr <= access & ~pready & ~mapped;
         prdata <= (access & ~pready & ~pwrite) ? rd_mux : 32'h00000000;
         if (wr_done && hit_ctrl) begin
            ctrl_reg <= pwdata[2:0];
         end
         // A new event in the clearing cycle keeps its sticky flag set.
         if (loss_pulse_reg) begin
            loss_seen_reg <= 1'b1;
         end else if (wr_done && hit_status && pwdata[`DLC_STAT_LOSS_SEEN]) begin
            loss_seen_reg <= 1'b0;
         end
         if (overflow_pulse_reg) begin
            overflow_reg <= 1'b1;
         end else if (wr_done && hit_status && pwdata[`DLC_STAT_OVERFLOW]) begin
            overflow_reg <= 1'b0;
         end
         // The loss counter saturates rather than wraps, so a long run never
         // reads back as fewer losses than really happened.
         if (loss_pulse_reg && loss_count_reg != 16'hFFFF) begin
            loss_count_reg <= loss_count_reg + 16'h0001;
         end
         // The word counter runs free and wraps; software should read differences.
         if (push_reg) begin
            word_count_reg <= word_count_reg + 32'h00000001;
         end
      end
   end
endmodule

// File: hw/dlc_word_buf.v
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Two-entry word buffer
// ----------------------------------------------------------------------------
// The head entry is the output register itself, so read data always come
// straight from a flip-flop.
module dlc_word_buf (
   input wire core_clk,
   input wire rst_n,
   input wire flush,
   input wire in_valid,
   output wire in_ready,
   input wire [9:0] in_data,
   output reg out_valid,
   input wire out_ready,
   output reg [9:0] out_data
);
   reg spare_valid_reg;
   reg [9:0] spare_data_reg;
   wire push;
   wire pop;

   assign in_ready = ~spare_valid_reg;
   assign push = in_valid & ~spare_valid_reg;
   assign pop = out_valid & out_ready;

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_valid <= 1'b0;
         out_data <= 10'h000;
         spare_valid_reg <= 1'b0;
         spare_data_reg <= 10'h000;
      end else if (flush) begin
         out_valid <= 1'b0;
         spare_valid_reg <= 1'b0;
      end else begin
         if (pop) begin
            if (spare_valid_reg) begin
               out_data <= spare_data_reg;
               spare_valid_reg <= 1'b0;
            end else if (push) begin
               out_data <= in_data;
            end else begin
               out_valid <= 1'b0;
            end
         end else if (push) begin
            if (out_valid) begin
               spare_data_reg <= in_data;
               spare_valid_reg <= 1'b1;
            end else begin
               out_data <= in_data;
               out_valid <= 1'b1;
            end
         end
      end
   end
endmodule

// File: include/dlc_defs.vh
`ifndef DLC_DEFS_VH
`define DLC_DEFS_VH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define DLC_OFS_CTRL 12'h000
`define DLC_OFS_STATUS 12'h004
`define DLC_OFS_LOSS_COUNT 12'h008
`define DLC_OFS_WORD_COUNT 12'h00C

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define DLC_CTRL_ENABLE 0
`define DLC_CTRL_SYNC_FEEDBACK 1
`define DLC_CTRL_FORCE_SYNC 2
`define DLC_CTRL_RESET 3'h3

// ----------------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------------
`define DLC_STAT_LOCKED 0
`define DLC_STAT_REF_OK 1
`define DLC_STAT_ACTIVITY 2
`define DLC_STAT_LOSS_SEEN 3
`define DLC_STAT_OVERFLOW 4

// ----------------------------------------------------------------------------
// Word framing and lock figures
// ----------------------------------------------------------------------------
`define DLC_DATA_BITS 10
`define DLC_FRAME_BITS 12
`define DLC_LAST_BIT 4'hB
`define DLC_HALF_BIT 4'h6
`define DLC_LOSS_WORDS 3'h4
`define DLC_LOCK_GOOD_WORDS 4'h8

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define DLC_CORE_PERIOD_NS 25
`define DLC_REF_TIMEOUT_NS 1000
// Forty core cycles, one microsecond at the core rate, sized to the watchdog timer.
`define DLC_REF_TIMEOUT_CYC 7'h28

`endif

// File: verification/dlc_lock_ctrl_properties.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------------
module dlc_lock_ctrl_properties (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic power_down_n,
   input wire logic output_enable,
   input wire logic word_ready,
   input wire logic word_valid,
   input wire logic [9:0] word_out,
   input wire logic word_oe,
   input wire logic lock_n_out,
   input wire logic lock_n_oe,
   input wire logic rclk_oe,
   input wire logic sync_request_a,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence apb_setup_s;
      psel && !penable;
   endsequence
   sequence apb_access_s;
      psel && penable;
   endsequence
   apb_wait_a: assert property (apb_setup_s ##1 apb_access_s |=> pready)
      else $error("pready not one wait state after access");
   pready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   pd_float_a: assert property (!power_down_n [*5] |-> !word_oe && !lock_n_oe && !rclk_oe)
      else $error("outputs driven in power down");
   en_float_a: assert property (!output_enable [*5] |-> !word_oe && !lock_n_oe && !rclk_oe)
      else $error("outputs driven while disabled");
   unlock_float_a: assert property (lock_n_out && $past(lock_n_out) |-> !word_oe && !rclk_oe)
      else $error("words driven while unlocked");
   oe_pair_a: assert property (word_oe == rclk_oe)
      else $error("word and clock enables differ");
   drive_lock_a: assert property (word_oe |-> !lock_n_out && lock_n_oe)
      else $error("words driven without lock indicator low");
   hold_word_a: assert property (word_valid && !word_ready && power_down_n |=>
      word_valid && $stable(word_out))
      else $error("stalled word lost or changed");
   sync_quiet_a: assert property (!lock_n_out && !$past(lock_n_out) |-> !sync_request_a)
      else $error("sync request while locked");
   lock_seen_c: cover property ($fell(lock_n_out));
endmodule

// File: verification/dlc_ser_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Serializer partner model
// ----------------------------------------------------------------------------
// The link clock stands still between calls, so idle gaps never look like bits.
module dlc_ser_model (
   output logic serial_clk,
   output logic serial_data,
   input wire logic sync_request_a,
   input wire logic sync_request_b
);
   initial begin
      serial_clk = 1'b0;
      serial_data = 1'b1;
   end
   task automatic send_frame(input logic [9:0] d, input logic bad);
      logic [11:0] f;
      f = {bad, d, ~bad};
      for (int i = 0; i < 12; i++) begin
         serial_data = f[i];
         #50 serial_clk = 1'b1;
         #100 serial_clk = 1'b0;
         #50;
      end
      serial_data = ~serial_data;
   endtask
   task automatic send_sync(input int max);
      int n;
      n = 0;
      while ((sync_request_a === 1'b1 || sync_request_b === 1'b1) && n < max) begin
         send_frame(10'h01F, 1'b0);
         #300;
         n++;
      end
   endtask
endmodule

// File: verification/tb_top.sv
`timescale 1ns/1ps
`include "dlc_defs.vh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
   $display("FAIL t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_top;
   logic core_clk, rst_n, ref_clk, ref_run, pd_n, oe_in, edge_sel, w_ready, hold;
   logic psel, penable, pwrite, pready, pslverr, sclk, sdata, sra, srb, err;
   logic word_oe, word_valid, lock_n, lock_oe, rclk, rclk_oe;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [9:0] word_out, d, sb_exp;
   logic [1:0] es_force;
   logic [9:0] exp_q[$];
   int miscompares, checks_done, cyc;
   dlc_lock_ctrl i_dut (.core_clk(core_clk), .rst_n(rst_n), .serial_clk_in(sclk),
      .serial_data_in(sdata), .reference_clock_in(ref_clk), .power_down_n(pd_n),
      .output_enable(oe_in), .edge_select(edge_sel), .sync_request_a(sra),
      .sync_request_b(srb), .word_out(word_out), .word_oe(word_oe), .word_valid(word_valid),
      .word_ready(w_ready), .lock_n_out(lock_n), .lock_n_oe(lock_oe), .rclk_out(rclk),
      .rclk_oe(rclk_oe), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   dlc_ser_model i_ser (.serial_clk(sclk), .serial_data(sdata), .sync_request_a(sra),
      .sync_request_b(srb));
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // The reference period is unrelated to the core clock, since one at the core rate
   // would alias to a constant level; it can be frozen to starve the watchdog.
   initial begin
      ref_clk = 1'b0;
      #3;
      forever #37 ref_clk = ref_run ? ~ref_clk : ref_clk;
   end
   always @(posedge core_clk) begin
      w_ready <= hold ? 1'b0 : ($urandom % 4 != 0);
      edge_sel <= es_force[1] ? es_force[0] : ($urandom % 2 == 1);
      cyc++;
      if (cyc == 80000) begin
         miscompares++;
         summarize();
      end
   end
   always @(posedge core_clk) begin
      if (rst_n === 1'b1 && word_valid === 1'b1 && w_ready === 1'b1) begin
         sb_exp = exp_q.size() > 0 ? exp_q.pop_front() : ~word_out;
         `CHK(word_out, sb_exp)
      end
   end
   task automatic summarize();
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) miscompares++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic frame(input logic bad, input logic push);
      d = 10'($urandom);
      if (push) exp_q.push_back(d);
      i_ser.send_frame(d, bad);
   endtask
   task automatic acquire();
      for (int i = 0; i < 60 && lock_n !== 1'b0; i++) begin
         frame(1'b0, 1'b0);
         repeat (8) @(posedge core_clk);
      end
   endtask
   task automatic wait_lock(input logic v);
      for (int i = 0; i < 60 && lock_n !== v; i++) @(posedge core_clk);
   endtask
   initial begin
      void'($urandom(32'hA1E2DA0F));
      rst_n = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {pd_n, oe_in, ref_run, w_ready, edge_sel, hold} = 6'b111100;
      es_force = 2'b00;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      apb(1'b0, `DLC_OFS_CTRL, 32'h0);
      `CHK(rd, 32'h3)
      `CHK({lock_oe, word_oe, rclk_oe}, 3'b000)
      apb(1'b0, 12'h010, 32'h0);
      `CHK({err, rd}, 33'h1_0000_0000)
      apb(1'b1, `DLC_OFS_CTRL, 32'h1);
      repeat (4) @(posedge core_clk);
      `CHK(sra, 1'b0)
      acquire();
      `CHK(lock_n, 1'b0)
      `CHK({lock_oe, word_oe, rclk_oe}, 3'b111)
      es_force = 2'b11;
      repeat (6) @(posedge core_clk);
      `CHK(rclk, 1'b0)
      es_force = 2'b10;
      repeat (6) @(posedge core_clk);
      `CHK(rclk, 1'b1)
      es_force = 2'b00;
      repeat (6) frame(1'b0, 1'b1);
      repeat (3) frame(1'b1, 1'b1);
      frame(1'b0, 1'b1);
      repeat (10) @(posedge core_clk);
      `CHK(lock_n, 1'b0)
      hold = 1'b1;
      repeat (2) frame(1'b0, 1'b1);
      repeat (2) frame(1'b0, 1'b0);
      hold = 1'b0;
      apb(1'b0, `DLC_OFS_STATUS, 32'h0);
      `CHK(rd[`DLC_STAT_OVERFLOW], 1'b1)
      apb(1'b1, `DLC_OFS_STATUS, 32'h10);
      apb(1'b0, `DLC_OFS_STATUS, 32'h0);
      `CHK(rd[`DLC_STAT_OVERFLOW], 1'b0)
      repeat (3) frame(1'b1, 1'b1);
      frame(1'b1, 1'b0);
      wait_lock(1'b1);
      `CHK(lock_n, 1'b1)
      repeat (3) @(posedge core_clk);
      `CHK({word_oe, rclk_oe}, 2'b00)
      apb(1'b1, `DLC_OFS_CTRL, 32'h3);
      repeat (4) @(posedge core_clk);
      `CHK(sra, 1'b1)
      i_ser.send_sync(40);
      wait_lock(1'b0);
      `CHK(lock_n, 1'b0)
      repeat (4) @(posedge core_clk);
      `CHK(sra, 1'b0)
      apb(1'b0, `DLC_OFS_LOSS_COUNT, 32'h0);
      `CHK(rd, 32'h1)
      apb(1'b0, `DLC_OFS_STATUS, 32'h0);
      `CHK(rd, 32'hF)
      apb(1'b0, `DLC_OFS_WORD_COUNT, 32'h0);
      `CHK(rd, 32'hF)
      apb(1'b1, `DLC_OFS_CTRL, 32'h5);
      repeat (4) @(posedge core_clk);
      `CHK(srb, 1'b1)
      apb(1'b1, `DLC_OFS_CTRL, 32'h1);
      ref_run = 1'b0;
      repeat (60) @(posedge core_clk);
      `CHK(lock_n, 1'b1)
      ref_run = 1'b1;
      acquire();
      `CHK(lock_n, 1'b0)
      oe_in <= 1'b0;
      repeat (6) @(posedge core_clk);
      `CHK({lock_oe, word_oe, rclk_oe}, 3'b000)
      oe_in <= 1'b1;
      repeat (6) @(posedge core_clk);
      `CHK({lock_oe, word_oe, rclk_oe}, 3'b111)
      pd_n <= 1'b0;
      repeat (6) @(posedge core_clk);
      `CHK({lock_oe, word_oe, rclk_oe}, 3'b000)
      pd_n <= 1'b1;
      acquire();
      `CHK(lock_n, 1'b0)
      summarize();
   end
endmodule
bind dlc_lock_ctrl dlc_lock_ctrl_properties i_props (.core_clk(core_clk), .rst_n(rst_n),
   .power_down_n(power_down_n), .output_enable(output_enable), .word_ready(word_ready),
   .word_valid(word_valid), .word_out(word_out), .word_oe(word_oe), .lock_n_out(lock_n_out),
   .lock_n_oe(lock_n_oe), .rclk_oe(rclk_oe), .sync_request_a(sync_request_a), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr));
